// ===== cpu_dp_consts.vh
// Purpose: Shared constants for the processor datapath
// Assumes: Included by cpu_status_alu_datapath.v
// Notes: Definitions only
`ifndef CPU_DP_CONSTS_VH
`define CPU_DP_CONSTS_VH
// Timing
`define CLK_PERIOD_NS 10
`define MICROCYCLE_NS 2000
`define MICROCYCLE_CLKS 16'h00C8
// Stack
`define STACK_WORDS 4'hA
// Status word bit positions
`define ST_OVF 6
`define ST_CRY 7
`define ST_LINK 8
`define ST_IEN 9
`define ST_BYTE 10
`define ST_UF_HI 14
`define ST_UF_LO 11
`define ST_LVL_HI 5
`define ST_LVL_LO 1
`define ST_REARM 4'hF
`define ST_NONE 4'h0
`define FLAG_RST 14'h0000
// Instruction fields
`define F_OP 15:12
`define F_DST 11:10
`define F_SRC 9:8
`define F_COND 11:8
`define F_IMM 7:0
`define F_SUB 2:0
`define F_FBIT 3:0
`define F_FVAL 4
`define F_PULL 0
// Opcodes
`define OP_NOP 4'h0
`define OP_ADD 4'h1
`define OP_DADD 4'h2
`define OP_AND 4'h3
`define OP_OR 4'h4
`define OP_XOR 4'h5
`define OP_UNA 4'h6
`define OP_LI 4'h7
`define OP_JMP 4'h8
`define OP_BOC 4'h9
`define OP_JSR 4'hA
`define OP_RTS 4'hB
`define OP_PSH 4'hC
`define OP_FLG 4'hD
`define OP_STX 4'hE
`define OP_RT0 4'hF
// Unary sub-operations
`define U_COMP 3'h0
`define U_SHL 3'h1
`define U_SHR 3'h2
`define U_ROL 3'h3
`define U_ROR 3'h4
`define U_MASK 3'h5
`define U_SXT 3'h6
// Status transfer sub-operations
`define X_TO_ACC 2'h0
`define X_FROM_ACC 2'h1
`define X_PUSH 2'h2
`define X_PULL 2'h3
// BCD digit correction
`define BCD_MAX 5'h09
`define BCD_ADJ 5'h06
// Vector locations
`define VEC_L0 16'h0007
`define VEC_BASE 16'h0001
// APB byte offsets and event register bit positions
`define A_CTRL 8'h00
`define A_STAT 8'h04
`define A_ACC0 8'h08
`define A_ACC1 8'h0C
`define A_ACC2 8'h10
`define A_ACC3 8'h14
`define A_PC 8'h18
`define A_EVT 8'h1C
`define EV_FULL 8
`define EV_EMPTY 9
`define EV_HOLD 10
`define EV_L0EN 11
`endif

// ===== cpu_status_alu_datapath.v
// Purpose: 16-bit processor datapath, status word, stack and control
// Assumes: APB3 slave, single clock, memory answers on MEM_ACK_I
// Notes: One microcycle is MICRO_CYC clocks
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "cpu_dp_consts.vh"
module cpu_status_alu_datapath #(
  parameter [15:0] MICRO_CYC = `MICROCYCLE_CLKS,
  parameter [3:0] DEPTH = `STACK_WORDS
) (
  input wire REF_CLK_I,
  input wire RST_I,
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [7:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output wire [31:0] PRDATA_O,
  output wire PREADY_O,
  output wire PSLVERR_O,
  output wire [15:0] MEM_ADDR_O,
  output wire MEM_RD_O,
  input wire [15:0] MEM_RDATA_I,
  input wire MEM_ACK_I,
  input wire [5:0] IRQ_N_I,
  input wire [3:0] SENSE_I,
  output wire [3:0] USER_FLAG_O,
  output wire STACK_FULL_O,
  output wire STACK_EMPTY_O
);
  localparam [1:0] S_FETCH = 2'h0;
  localparam [1:0] S_INST = 2'h1;
  localparam [1:0] S_EXEC = 2'h2;
  localparam [1:0] S_VEC = 2'h3;

  function amap;
    input [7:0] a;
    begin
      case (a)
        `A_CTRL, `A_STAT, `A_ACC0, `A_ACC1, `A_ACC2, `A_ACC3, `A_PC, `A_EVT: amap = 1'b1;
        default: amap = 1'b0;
      endcase
    end
  endfunction

  // Returns {link, overflow, carry, result}
  function [18:0] alu;
    input [3:0] op;
    input [2:0] sub;
    input [15:0] a;
    input [15:0] b;
    input ci;
    input li;
    input bm;
    reg [16:0] s;
    reg [4:0] d;
    reg c;
    reg c8;
    reg v;
    reg l;
    reg [15:0] r;
    integer i;
    begin
      s = 17'h00000;
      d = 5'h00;
      c = ci;
      c8 = ci;
      v = 1'b0;
      l = li;
      r = 16'h0000;
      case (op)
        `OP_ADD: begin
          s = {1'b0, a} + {1'b0, b};
          r = s[15:0];
          c = bm ? (a[8] ^ b[8] ^ r[8]) : s[16];
          v = bm ? ((a[7] == b[7]) && (r[7] != a[7])) : ((a[15] == b[15]) && (r[15] != a[15]));
        end
        `OP_DADD: begin
          for (i = 0; i < 4; i = i + 1) begin
            d = {1'b0, a[i*4+:4]} + {1'b0, b[i*4+:4]} + {4'h0, c};
            if (d > `BCD_MAX) begin
              d = d + `BCD_ADJ;
            end
            r[i*4+:4] = d[3:0];
            c = d[4];
            if (i == 1) begin
              c8 = d[4];
            end
          end
          if (bm) begin
            c = c8;
          end
        end
        `OP_AND: r = a & b;
        `OP_OR: r = a | b;
        `OP_XOR: r = a ^ b;
        default: begin
          case (sub)
            `U_COMP: r = ~a;
            `U_SHL: begin
              r = bm ? {a[15:8], a[6:0], 1'b0} : {a[14:0], 1'b0};
              l = bm ? a[7] : a[15];
            end
            `U_SHR: begin
              r = bm ? {a[15:8], 1'b0, a[7:1]} : {1'b0, a[15:1]};
              l = a[0];
            end
            `U_ROL: begin
              r = bm ? {a[15:8], a[6:0], li} : {a[14:0], li};
              l = bm ? a[7] : a[15];
            end
            `U_ROR: begin
              r = bm ? {a[15:8], li, a[7:1]} : {li, a[15:1]};
              l = a[0];
            end
            `U_MASK: r = {8'h00, a[7:0]};
            `U_SXT: r = {{8{a[7]}}, a[7:0]};
            default: r = a;
          endcase
        end
      endcase
      // Byte mode keeps the upper byte of the destination untouched, except for the mask and sign-extend unary operations
      if (bm && !((op == `OP_UNA) && ((sub == `U_MASK) || (sub == `U_SXT)))) begin
        r = {a[15:8], r[7:0]};
      end
      alu = {l, v, c, r};
    end
  endfunction

  reg [15:0] acc_q [0:3];
  reg [15:0] stk [0:DEPTH-1];
  reg [14:1] flag_q;
  reg l0_en_q;
  reg hold_q;
  reg run_q;
  reg [15:0] pc_q;
  reg [15:0] ir_q;
  reg [15:0] tmpa_q;
  reg [15:0] tmpb_q;
  reg [3:0] sp_q;
  reg full_ev_q;
  reg empty_ev_q;
  reg [1:0] st_q;
  reg mem_rd_q;
  reg [15:0] tick_cnt_q;
  reg [5:0] irq_m_q;
  reg [5:0] irq_s_q;
  reg [5:0] req_q;
  reg [3:0] sns_m_q;
  reg [3:0] sns_s_q;
  reg [31:0] prdata_q;
  reg push_en;
  reg pop_en;
  reg [15:0] push_d;
  reg [5:0] req_clr;
  reg [2:0] lvl;
  reg cond_w;
  reg [31:0] rd_w;
  integer k;
  integer j;

  wire [15:0] stat_w = {1'b1, flag_q, 1'b1};
  wire bm = flag_q[`ST_BYTE];
  wire [3:0] op = ir_q[`F_OP];
  wire [2:0] sub = ir_q[`F_SUB];
  wire [3:0] fbit = ir_q[`F_FBIT];
  wire [15:0] a_w = acc_q[ir_q[`F_DST]];
  wire [15:0] b_w = acc_q[ir_q[`F_SRC]];
  wire [15:0] disp = {{8{ir_q[7]}}, ir_q[`F_IMM]};
  wire [18:0] alu_w = alu(op, sub, a_w, b_w, flag_q[`ST_CRY], flag_q[`ST_LINK], bm);
  wire tick = (tick_cnt_q >= MICRO_CYC - 16'h0001);
  wire exec_w = (st_q == S_EXEC) && tick;
  wire start_w = (st_q == S_FETCH) && tick && run_q;
  wire take0 = req_q[0] && !hold_q;
  wire take_n = flag_q[`ST_IEN] && (|req_q[5:1]) && !hold_q;
  wire full_w = (sp_q == DEPTH);
  wire push_ok = push_en && !full_w;
  wire pop_ok = pop_en && (sp_q != 4'h0);
  wire [15:0] top_w = (sp_q == 4'h0) ? 16'h0000 : stk[sp_q - 4'h1];
  wire [5:0] req_set = {irq_s_q[5:1] & flag_q[`ST_LVL_HI:`ST_LVL_LO], irq_s_q[0] & l0_en_q};
  wire apb_wr = PSEL_I && PENABLE_I && PWRITE_I && amap(PADDR_I);
  wire [15:0] zmask = bm ? 16'h00FF : 16'hFFFF;
  wire zero_w = ((acc_q[0] & zmask) == 16'h0000);
  wire sign_w = bm ? acc_q[0][7] : acc_q[0][15];

  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !amap(PADDR_I);
  assign PRDATA_O = prdata_q;
  assign MEM_ADDR_O = tmpa_q;
  assign MEM_RD_O = mem_rd_q;
  assign USER_FLAG_O = flag_q[`ST_UF_HI:`ST_UF_LO];
  assign STACK_FULL_O = full_ev_q;
  assign STACK_EMPTY_O = empty_ev_q;

  // Branch condition select
  always @* begin
    case (ir_q[`F_COND])
      4'h0: cond_w = full_w;
      4'h1: cond_w = zero_w;
      4'h2: cond_w = !sign_w;
      4'h3: cond_w = acc_q[0][0];
      4'h4: cond_w = acc_q[0][1];
      4'h5: cond_w = !zero_w;
      4'h6: cond_w = acc_q[0][2];
      4'h7: cond_w = sns_s_q[0];
      4'h8: cond_w = flag_q[`ST_LINK];
      4'h9: cond_w = flag_q[`ST_IEN];
      4'hA: cond_w = flag_q[`ST_CRY];
      4'hB: cond_w = sign_w;
      4'hC: cond_w = flag_q[`ST_OVF];
      4'hD: cond_w = sns_s_q[1];
      4'hE: cond_w = sns_s_q[2];
      default: cond_w = sns_s_q[3];
    endcase
  end

  // Stack traffic and interrupt acknowledge
  always @* begin
    push_en = 1'b0;
    pop_en = 1'b0;
    push_d = 16'h0000;
    req_clr = 6'h00;
    lvl = 3'h5;
    for (k = 5; k >= 1; k = k - 1) begin
      if (req_q[k]) begin
        lvl = k[2:0];
      end
    end
    if (start_w && take0) begin
      req_clr[0] = 1'b1;
    end else if (start_w && take_n) begin
      req_clr[lvl] = 1'b1;
      push_en = 1'b1;
      push_d = pc_q;
    end
    if (exec_w) begin
      case (op)
        `OP_JSR: begin
          push_en = 1'b1;
          push_d = pc_q;
        end
        `OP_RTS: pop_en = 1'b1;
        `OP_PSH: begin
          pop_en = ir_q[`F_PULL];
          push_en = !ir_q[`F_PULL];
          push_d = b_w;
        end
        `OP_STX: begin
          push_en = (sub[1:0] == `X_PUSH);
          pop_en = (sub[1:0] == `X_PULL);
          push_d = stat_w;
        end
        default: push_en = 1'b0;
      endcase
    end
  end

  // APB read data, taken in the setup phase
  always @* begin
    case (PADDR_I)
      `A_CTRL: rd_w = {31'h0000000, run_q};
      `A_STAT: rd_w = {16'h0000, stat_w};
      `A_ACC0: rd_w = {16'h0000, acc_q[0]};
      `A_ACC1: rd_w = {16'h0000, acc_q[1]};
      `A_ACC2: rd_w = {16'h0000, acc_q[2]};
      `A_ACC3: rd_w = {16'h0000, acc_q[3]};
      `A_PC: rd_w = {16'h0000, pc_q};
      `A_EVT: rd_w = {20'h00000, l0_en_q, hold_q, empty_ev_q, full_ev_q, 4'h0, sp_q};
      default: rd_w = 32'h00000000;
    endcase
  end

  // Stack storage needs no reset; the pointer defines what is valid
  always @(posedge REF_CLK_I) begin
    if (push_ok) begin
      stk[sp_q] <= push_d;
    end
  end

  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      irq_m_q <= 6'h00;
      irq_s_q <= 6'h00;
      sns_m_q <= 4'h0;
      sns_s_q <= 4'h0;
      prdata_q <= 32'h00000000;
    end else begin
      irq_m_q <= ~IRQ_N_I;
      irq_s_q <= irq_m_q;
      sns_m_q <= SENSE_I;
      sns_s_q <= sns_m_q;
      if (PSEL_I && !PENABLE_I) begin
        prdata_q <= rd_w;
      end
    end
  end

  always @(posedge REF_CLK_I) begin
    if (RST_I) begin
      for (j = 0; j < 4; j = j + 1) begin
        acc_q[j] <= 16'h0000;
      end
      flag_q <= `FLAG_RST;
      l0_en_q <= 1'b1;
      hold_q <= 1'b0;
      run_q <= 1'b0;
      pc_q <= 16'h0000;
      ir_q <= 16'h0000;
      tmpa_q <= 16'h0000;
      tmpb_q <= 16'h0000;
      sp_q <= 4'h0;
      full_ev_q <= 1'b0;
      empty_ev_q <= 1'b0;
      st_q <= S_FETCH;
      mem_rd_q <= 1'b0;
      tick_cnt_q <= 16'h0000;
      req_q <= 6'h00;
    end else begin
      // Microcycle pacing; tick marks the last clock of each one
      tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
      req_q <= (req_q & ~req_clr) | req_set;
      if (push_ok) begin
        sp_q <= sp_q + 4'h1;
      end else if (pop_ok) begin
        sp_q <= sp_q - 4'h1;
      end
      // Software clears first so that a same-cycle event still lands
      if (apb_wr && (PADDR_I == `A_EVT)) begin
        if (PWDATA_I[`EV_FULL]) begin
          full_ev_q <= 1'b0;
        end
        if (PWDATA_I[`EV_EMPTY]) begin
          empty_ev_q <= 1'b0;
        end
      end
      if (push_ok && (sp_q == DEPTH - 4'h1)) begin
        full_ev_q <= 1'b1;
      end
      if (pop_ok && (sp_q == 4'h1)) begin
        empty_ev_q <= 1'b1;
      end
      if (apb_wr) begin
        case (PADDR_I)
          `A_CTRL: run_q <= PWDATA_I[0];
          `A_STAT: flag_q <= PWDATA_I[14:1];
          `A_ACC0: acc_q[0] <= PWDATA_I[15:0];
          `A_ACC1: acc_q[1] <= PWDATA_I[15:0];
          `A_ACC2: acc_q[2] <= PWDATA_I[15:0];
          `A_ACC3: acc_q[3] <= PWDATA_I[15:0];
          default: run_q <= run_q;
        endcase
      end
      // Core updates come last and win over a colliding bus write
      case (st_q)
        S_FETCH: begin
          if (start_w) begin
            hold_q <= 1'b0;
            mem_rd_q <= 1'b1;
            if (take0) begin
              l0_en_q <= 1'b0;
              tmpb_q <= pc_q;
              tmpa_q <= `VEC_L0;
              st_q <= S_VEC;
            end else if (take_n) begin
              flag_q[`ST_IEN] <= 1'b0;
              tmpa_q <= `VEC_BASE + {13'h0000, lvl};
              st_q <= S_VEC;
            end else begin
              tmpa_q <= pc_q;
              st_q <= S_INST;
            end
          end
        end
        S_INST: begin
          if (MEM_ACK_I) begin
            ir_q <= MEM_RDATA_I;
            pc_q <= pc_q + 16'h0001;
            mem_rd_q <= 1'b0;
            st_q <= S_EXEC;
          end
        end
        S_VEC: begin
          if (MEM_ACK_I) begin
            pc_q <= MEM_RDATA_I;
            mem_rd_q <= 1'b0;
            st_q <= S_FETCH;
          end
        end
        S_EXEC: begin
          if (tick) begin
            st_q <= S_FETCH;
            case (op)
              `OP_ADD: begin
                acc_q[ir_q[`F_DST]] <= alu_w[15:0];
                flag_q[`ST_CRY] <= alu_w[16];
                flag_q[`ST_OVF] <= alu_w[17];
              end
              `OP_DADD: begin
                acc_q[ir_q[`F_DST]] <= alu_w[15:0];
                flag_q[`ST_CRY] <= alu_w[16];
              end
              `OP_AND, `OP_OR, `OP_XOR: acc_q[ir_q[`F_DST]] <= alu_w[15:0];
              `OP_UNA: begin
                acc_q[ir_q[`F_DST]] <= alu_w[15:0];
                flag_q[`ST_LINK] <= alu_w[18];
              end
              `OP_LI: acc_q[ir_q[`F_DST]] <= disp;
              `OP_JMP, `OP_JSR: pc_q <= pc_q + disp;
              `OP_BOC: begin
                if (cond_w) begin
                  pc_q <= pc_q + disp;
                end
              end
              `OP_RTS: begin
                if (sp_q != 4'h0) begin
                  pc_q <= top_w;
                end
              end
              `OP_PSH: begin
                if (ir_q[`F_PULL] && (sp_q != 4'h0)) begin
                  acc_q[ir_q[`F_DST]] <= top_w;
                end
              end
              `OP_FLG: begin
                if (fbit == `ST_REARM) begin
                  if (ir_q[`F_FVAL]) begin
                    l0_en_q <= 1'b1;
                    hold_q <= 1'b1;
                  end
                end else if (fbit != `ST_NONE) begin
                  flag_q[fbit] <= ir_q[`F_FVAL];
                end
              end
              `OP_STX: begin
                case (sub[1:0])
                  `X_TO_ACC: acc_q[ir_q[`F_DST]] <= stat_w;
                  `X_FROM_ACC: flag_q <= b_w[14:1];
                  `X_PULL: begin
                    if (sp_q != 4'h0) begin
                      flag_q <= top_w[14:1];
                    end
                  end
                  default: hold_q <= hold_q;
                endcase
              end
              `OP_RT0: pc_q <= tmpb_q;
              default: hold_q <= hold_q;
            endcase
          end
        end
        default: st_q <= S_FETCH;
      endcase
    end
  end
endmodule

// ===== cpu_dp_assertions.sv
// Purpose: Port checks for the processor datapath
// Assumes: Status is written over APB only while the core is stopped
// Notes: Bound to every datapath instance
`timescale 1ns/10ps
module cpu_dp_assertions (
  input wire REF_CLK_I,
  input wire RST_I,
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [7:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  input wire [31:0] PRDATA_O,
  input wire [15:0] MEM_ADDR_O,
  input wire MEM_RD_O,
  input wire MEM_ACK_I,
  input wire [3:0] USER_FLAG_O,
  input wire STACK_FULL_O,
  input wire STACK_EMPTY_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  wire rd_set = PSEL_I && !PENABLE_I && !PWRITE_I;
  wire wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
  wire evt_wr = wr_acc && PADDR_I == 8'h1C;
  wire [3:0] flag_wr = PWDATA_I[14:11];
  chk_status_ones: assert property (rd_set && PADDR_I == 8'h04 |=> PRDATA_O[15] && PRDATA_O[0])
    else $error("status bits 15 and 0 not one");
  chk_upper_zero: assert property (rd_set |=> PRDATA_O[31:16] == 16'h0000)
    else $error("read upper half not zero");
  chk_flag_pins: assert property (wr_acc && PADDR_I == 8'h04 |=> USER_FLAG_O == $past(flag_wr))
    else $error("flag pins do not follow status write");
  chk_status_pins: assert property (rd_set && PADDR_I == 8'h04 |=> PRDATA_O[14:11] == USER_FLAG_O)
    else $error("flag pins differ from status bits");
  chk_mem_hold: assert property (MEM_RD_O && !MEM_ACK_I |=> MEM_RD_O && $stable(MEM_ADDR_O))
    else $error("fetch request not held");
  chk_mem_drop: assert property (MEM_RD_O && MEM_ACK_I |=> !MEM_RD_O)
    else $error("fetch request kept after ack");
  chk_full_sticky: assert property (STACK_FULL_O && !(evt_wr && PWDATA_I[8]) |=> STACK_FULL_O)
    else $error("full event lost");
  chk_empty_sticky: assert property (STACK_EMPTY_O && !(evt_wr && PWDATA_I[9]) |=> STACK_EMPTY_O)
    else $error("empty event lost");
  chk_init_state: assert property ($fell(RST_I) |-> !STACK_FULL_O && !STACK_EMPTY_O && USER_FLAG_O == 4'h0)
    else $error("state after init wrong");
  chk_fetch_quiet: assert property ($fell(RST_I) |-> !MEM_RD_O [*3])
    else $error("fetch before run");
endmodule
bind cpu_status_alu_datapath cpu_dp_assertions cpu_dp_assertions_i (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PRDATA_O(PRDATA_O), .MEM_ADDR_O(MEM_ADDR_O), .MEM_RD_O(MEM_RD_O), .MEM_ACK_I(MEM_ACK_I),
  .USER_FLAG_O(USER_FLAG_O), .STACK_FULL_O(STACK_FULL_O), .STACK_EMPTY_O(STACK_EMPTY_O));

// ===== prog_mem_model.sv
// Purpose: Program memory beside the core
// Assumes: One read outstanding at a time
// Notes: Slow mode waits three cycles before answering
`timescale 1ns/10ps
module prog_mem_model (
  input wire clk_i,
  input wire rd_i,
  input wire [15:0] addr_i,
  input wire slow_i,
  output logic [15:0] data_o,
  output logic ack_o
);
  logic [15:0] mem [0:255];
  int wait_n;
  initial begin
    data_o = 16'hA5A5;
    ack_o = 1'b0;
    wait_n = 0;
  end
  always @(posedge clk_i) begin
    if (ack_o) begin
      // Word is gone after the ack, so stale data must not look valid
      ack_o <= 1'b0;
      data_o <= ~data_o;
    end else if (rd_i) begin
      if (slow_i && wait_n < 3) begin
        wait_n <= wait_n + 1;
      end else begin
        ack_o <= 1'b1;
        data_o <= mem[addr_i[7:0]];
        wait_n <= 0;
      end
    end
  end
endmodule

// ===== cpu_status_alu_datapath_test.sv
// Purpose: Self-checking bench for the processor datapath
// Assumes: Short microcycle; interrupt lines idle except interrupt level 1 in the control test
// Notes: A monitor checks reads against queued notes
`timescale 1ns/10ps
module cpu_status_alu_datapath_test;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic clk, rst, psel, pen, pwr, slow, ovf, lk;
  logic [5:0] irq_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, d;
  logic [3:0] sense;
  logic [15:0] a, b;
  logic [16:0] w;
  wire [31:0] prdata;
  wire pready, perr, mrd, ack, sfull, sempty;
  wire [15:0] maddr, mdata;
  wire [3:0] uflag;
  logic [31:0] eq[$], mq[$];
  int n_errors, checks, i;
  cpu_status_alu_datapath #(.MICRO_CYC(16'h0004), .DEPTH(4'hA)) cpu_status_alu_datapath_i (
    .REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr), .MEM_ADDR_O(maddr),
    .MEM_RD_O(mrd), .MEM_RDATA_I(mdata), .MEM_ACK_I(ack), .IRQ_N_I(irq_n), .SENSE_I(sense),
    .USER_FLAG_O(uflag), .STACK_FULL_O(sfull), .STACK_EMPTY_O(sempty));
  prog_mem_model prog_mem_model_i (.clk_i(clk), .rd_i(mrd), .addr_i(maddr), .slow_i(slow),
    .data_o(mdata), .ack_o(ack));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Automatic: the monitor and the main thread may both call it on one edge
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] ad, input logic [31:0] dv, input logic [31:0] m);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= ad;
    pwdata <= wr ? dv : $urandom;
    if (!wr) begin
      eq.push_back(dv & m);
      mq.push_back(m);
    end
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  always @(posedge clk) begin
    if (psel && pen && pready === 1'b1) begin
      check(perr, (paddr > 8'h1C) || (paddr[1:0] != 2'h0));
    end
    if (psel && pen && !pwr && pready === 1'b1) begin
      check(prdata & mq[0], eq[0]);
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
  end
  task do_reset(input int n);
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 256; i++) prog_mem_model_i.mem[i] = 16'h0000;
  endtask
  task run_prog(input int n);
    apb(1'b1, 8'h00, 32'h1, ALL);
    repeat (n) @(posedge clk);
    apb(1'b1, 8'h00, 32'h0, ALL);
    repeat (20) @(posedge clk);
  endtask
  task results;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    // Cut a hang well past the expected run of about 1300 cycles
    #200000;
    n_errors++;
    results;
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    slow = 1'b0;
    n_errors = 0;
    checks = 0;
    void'($urandom(32'hECC5A898));
    sense = 4'h0;
    irq_n = 6'h3F;
    do_reset(12);
    apb(1'b0, 8'h04, 32'h8001, ALL);
    apb(1'b0, 8'h1C, 32'h0800, ALL);
    apb(1'b0, 8'h18, 32'h0, ALL);
    $display("test reset done");
    repeat (4) begin
      d = $urandom;
      apb(1'b1, 8'h04, d, ALL);
      apb(1'b0, 8'h04, (d & 32'h7FFE) | 32'h8001, ALL);
      check(uflag, d[14:11]);
    end
    for (i = 0; i < 4; i++) begin
      d = $urandom;
      paddr <= 8'h08 + 8'(4 * i);
      apb(1'b1, 8'h08 + 8'(4 * i), d, ALL);
      apb(1'b0, 8'h08 + 8'(4 * i), d & 32'hFFFF, ALL);
    end
    apb(1'b1, 8'h20, ALL, ALL);
    apb(1'b0, 8'h20, 32'h0, ALL);
    $display("test registers done");
    do_reset(2);
    prog_mem_model_i.mem[0] = 16'h2B00;
    prog_mem_model_i.mem[1] = 16'h1100;
    prog_mem_model_i.mem[2] = 16'hD01C;
    a = $urandom;
    b = $urandom;
    w = a + b;
    ovf = (a[15] == b[15]) && (w[15] != a[15]);
    apb(1'b1, 8'h08, {16'h0, a}, ALL);
    apb(1'b1, 8'h0C, {16'h0, b}, ALL);
    apb(1'b1, 8'h10, 32'h9999, ALL);
    apb(1'b1, 8'h14, 32'h0001, ALL);
    slow <= 1'b1;
    run_prog(200);
    apb(1'b0, 8'h08, {16'h0, w[15:0]}, ALL);
    apb(1'b0, 8'h10, 32'h0, ALL);
    apb(1'b0, 8'h04, {19'h0, 1'b1, 4'h0, w[16], ovf, 6'h0}, 32'h10C0);
    check(uflag, 4'h2);
    $display("test arithmetic done");
    do_reset(2);
    prog_mem_model_i.mem[0] = 16'h1100;
    apb(1'b1, 8'h04, 32'h0400, ALL);
    apb(1'b1, 8'h08, 32'h12FF, ALL);
    apb(1'b1, 8'h0C, 32'h0001, ALL);
    run_prog(100);
    apb(1'b0, 8'h08, 32'h1200, ALL);
    apb(1'b0, 8'h04, 32'h0080, 32'h01C0);
    $display("test byte mode done");
    do_reset(2);
    for (i = 0; i < 22; i++) prog_mem_model_i.mem[i] = (i < 11) ? 16'hC000 : 16'hC001;
    d = $urandom;
    apb(1'b1, 8'h08, d, ALL);
    slow <= 1'b0;
    run_prog(600);
    apb(1'b0, 8'h1C, 32'h0300, 32'h030F);
    apb(1'b0, 8'h08, d & 32'hFFFF, ALL);
    check({sfull, sempty}, 2'b11);
    apb(1'b1, 8'h1C, 32'h0300, ALL);
    apb(1'b0, 8'h1C, 32'h0, 32'h030F);
    check({sfull, sempty}, 2'b00);
    $display("test stack done");
    do_reset(2);
    prog_mem_model_i.mem[2] = 16'h0010;
    prog_mem_model_i.mem[16] = 16'h9D02;
    prog_mem_model_i.mem[17] = 16'h7401;
    prog_mem_model_i.mem[19] = 16'h6803;
    a = $urandom;
    lk = $urandom;
    sense <= 4'($urandom);
    irq_n <= 6'h3D;
    apb(1'b1, 8'h04, {22'h0, 1'b1, lk, 6'h00, 1'b1, 1'b0}, ALL);
    apb(1'b1, 8'h10, {16'h0, a}, ALL);
    run_prog(150);
    irq_n <= 6'h3F;
    apb(1'b0, 8'h0C, {31'h0, !sense[1]}, ALL);
    apb(1'b0, 8'h10, {16'h0, a[14:0], lk}, ALL);
    apb(1'b0, 8'h04, {16'h0, 1'b1, 6'h00, a[15], 6'h00, 2'b11}, ALL);
    apb(1'b0, 8'h1C, 32'h0001, 32'h030F);
    $display("test control done");
    results;
  end
endmodule
